// ==== hw/flash_status_pkg.sv ====
/*
 Shared constants of the two-byte flash status register logic: bit positions
 of both bytes, values after power-up, the operation codes reported by the
 command front end, and the pattern for global protect and unprotect.
 Assumes the front end decodes the serial commands and reports each finished
 or aborted operation as one pulse.
*/
package flash_status_pkg;

   // ----------------------------------------------------------------
   // status byte one bit positions
   // ----------------------------------------------------------------
   localparam int B1_LOCK = 7;
   localparam int B1_FAIL = 5;
   localparam int B1_PIN = 4;
   localparam int B1_SUM_HI = 3;
   localparam int B1_SUM_LO = 2;
   localparam int B1_LATCH = 1;
   localparam int B1_BUSY = 0;

   // ----------------------------------------------------------------
   // status byte two bit positions
   // ----------------------------------------------------------------
   localparam int B2_RST_ALLOW = 4;
   localparam int B2_LD_ALLOW = 3;
   localparam int B2_PSUSP = 2;
   localparam int B2_ESUSP = 1;
   localparam int B2_BUSY = 0;

   // ----------------------------------------------------------------
   // values after power-up
   // ----------------------------------------------------------------
   localparam logic RST_LOCK = 1'b0;
   localparam logic RST_FAIL = 1'b0;
   localparam logic RST_LATCH = 1'b0;
   localparam logic RST_PIN = 1'b0;
   localparam logic RST_RST_ALLOW = 1'b0;
   localparam logic RST_LD_ALLOW = 1'b0;
   localparam logic RST_FROZEN = 1'b0;
   localparam logic [1:0] RST_SUMMARY = 2'h3;
   localparam logic [7:0] RST_BYTE = 8'h00;

   // ----------------------------------------------------------------
   // protection summary codes
   // ----------------------------------------------------------------
   localparam logic [1:0] SUM_NONE = 2'h0;
   localparam logic [1:0] SUM_SOME = 2'h1;
   localparam logic [1:0] SUM_ALL = 2'h3;

   // ----------------------------------------------------------------
   // global protect pattern in bits 5:2 of the byte one write data
   // ----------------------------------------------------------------
   localparam int GLOB_HI = 5;
   localparam int GLOB_LO = 2;
   localparam logic [3:0] GLOB_PROTECT = 4'hf;
   localparam logic [3:0] GLOB_UNPROTECT = 4'h0;

   // ----------------------------------------------------------------
   // operations reported by the command front end
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_NONE = 4'h0,
      OP_WR_ENABLE = 4'h1,
      OP_WR_DISABLE = 4'h2,
      OP_WR_STAT1 = 4'h3,
      OP_WR_STAT2 = 4'h4,
      OP_WR_CONFIG = 4'h5,
      OP_PROTECT = 4'h6,
      OP_UNPROTECT = 4'h7,
      OP_LOCKDOWN = 4'h8,
      OP_FREEZE = 4'h9,
      OP_OTP_PROG = 4'ha,
      OP_PROGRAM = 4'hb,
      OP_ERASE = 4'hc,
      OP_HOLD_ABORT = 4'hd
   } op_kind_t;

endpackage

// ==== hw/flash_status_regs.sv ====
/*
 Status register logic of a serial flash: both status bytes, the write
 latch, the lock, the error flag, the reset and lockdown enables, and the
 permission levels that gate the command engine.
 Assumes a command front end that reports one operation end per cycle at
 most, and internal engines that drive busy, suspend and protection levels.
*/
`timescale 1ns/1ps
`default_nettype none

module flash_status_regs (
   // clock and power-up reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // operation end report from the command front end
   input wire logic op_end_i,
   input wire logic [3:0] op_kind_i,
   input wire logic op_abort_i,
   input wire logic op_fail_i,
   input wire logic [7:0] op_data_i,
   // software reset command, already decoded
   input wire logic soft_reset_i,
   // pins and internal engine state
   input wire logic wp_n_i,
   input wire logic busy_i,
   input wire logic prog_susp_i,
   input wire logic erase_susp_i,
   input wire logic none_protected_i,
   input wire logic all_protected_i,
   // status bytes as shifted out by the read command
   output logic [7:0] status_byte_one_o,
   output logic [7:0] status_byte_two_o,
   // permissions towards the command engine
   output logic latch_gate_ok_o,
   output logic sector_prot_ok_o,
   output logic lockdown_ok_o,
   output logic soft_reset_ok_o,
   // global protect requests, one cycle each
   output logic global_protect_o,
   output logic global_unprotect_o
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic protection_lock_bit;
      logic program_fail_flag;
      logic protect_pin_state;
      logic [1:0] soft_protect_summary;
      logic write_latch;
      logic ready_busy_flag;
      logic soft_reset_allow;
      logic lockdown_allow;
      logic frozen;
      logic prog_suspended_flag;
      logic erase_suspended_flag;
      logic glob_prot;
      logic glob_unprot;
      logic [7:0] byte_one;
      logic [7:0] byte_two;
      logic gate_ok;
      logic sector_ok;
      logic ld_ok;
      logic rst_ok;
   } state_t;

   state_t state_reg;
   state_t state_next;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [1:0] summary_code(input logic none_p,
                                               input logic all_p);
      logic [1:0] code;
      // all wins over none, so the reserved code can never show
      code = flash_status_pkg::SUM_SOME;
      if (all_p) begin
         code = flash_status_pkg::SUM_ALL;
      end else if (none_p) begin
         code = flash_status_pkg::SUM_NONE;
      end
      return code;
   endfunction

   function automatic logic is_kind(input logic [3:0] kind,
                                    input flash_status_pkg::op_kind_t ref_k);
      return kind == 4'(ref_k);
   endfunction

   // a gated write counts only with the latch set and a clean end; the
   // abort report covers partial bytes and protected targets alike
   function automatic logic write_taken(input logic latch,
                                        input logic abort);
      return latch && !abort;
   endfunction

   // clearing the lock with the pin asserted voids the whole write, the
   // global operation included; the latch is still dropped
   logic lock_clear_blocked;
   assign lock_clear_blocked = !wp_n_i && state_reg.protection_lock_bit &&
      !op_data_i[flash_status_pkg::B1_LOCK];

   logic [3:0] glob_field;
   assign glob_field = op_data_i[flash_status_pkg::GLOB_HI:
                                 flash_status_pkg::GLOB_LO];

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      state_next.glob_prot = 1'b0;
      state_next.glob_unprot = 1'b0;

      // live mirrors of internal engines and the pin
      state_next.protect_pin_state = wp_n_i;
      state_next.ready_busy_flag = busy_i;
      state_next.prog_suspended_flag = prog_susp_i;
      state_next.erase_suspended_flag = erase_susp_i;
      state_next.soft_protect_summary =
         summary_code(none_protected_i, all_protected_i);

      if (op_end_i) begin
         // aborted enable or disable reports leave the latch as it was
         if (is_kind(op_kind_i, flash_status_pkg::OP_WR_ENABLE)) begin
            if (!op_abort_i) begin
               state_next.write_latch = 1'b1;
            end
         end else if (is_kind(op_kind_i,
                              flash_status_pkg::OP_WR_DISABLE)) begin
            if (!op_abort_i) begin
               state_next.write_latch = 1'b0;
            end
         end else if (is_kind(op_kind_i,
                              flash_status_pkg::OP_WR_STAT1)) begin
            // only bit 7 of the data is stored; bits 5:2 only steer
            // the global operation and leave no trace
            if (write_taken(state_reg.write_latch, op_abort_i)) begin
               if (!lock_clear_blocked) begin
                  state_next.protection_lock_bit =
                     op_data_i[flash_status_pkg::B1_LOCK];
                  // the global operation follows the lock as it stood
                  // before this write
                  if (!state_reg.protection_lock_bit) begin
                     state_next.glob_prot =
                        glob_field == flash_status_pkg::GLOB_PROTECT;
                     state_next.glob_unprot =
                        glob_field == flash_status_pkg::GLOB_UNPROTECT;
                  end
               end
            end
            state_next.write_latch = 1'b0;
         end else if (is_kind(op_kind_i,
                              flash_status_pkg::OP_WR_STAT2)) begin
            if (write_taken(state_reg.write_latch, op_abort_i)) begin
               state_next.soft_reset_allow =
                  op_data_i[flash_status_pkg::B2_RST_ALLOW];
               if (!state_reg.frozen) begin
                  state_next.lockdown_allow =
                     op_data_i[flash_status_pkg::B2_LD_ALLOW];
               end
            end
            state_next.write_latch = 1'b0;
         end else if (is_kind(op_kind_i, flash_status_pkg::OP_FREEZE)) begin
            if (write_taken(state_reg.write_latch, op_abort_i) &&
                state_reg.lockdown_allow) begin
               state_next.frozen = 1'b1;
            end
            state_next.write_latch = 1'b0;
         end else if (is_kind(op_kind_i, flash_status_pkg::OP_PROGRAM) ||
                      is_kind(op_kind_i, flash_status_pkg::OP_ERASE)) begin
            // an aborted or rejected operation reports no error
            state_next.program_fail_flag = op_fail_i &&
               write_taken(state_reg.write_latch, op_abort_i);
            state_next.write_latch = 1'b0;
         end else if (is_kind(op_kind_i,
                              flash_status_pkg::OP_WR_CONFIG) ||
                      is_kind(op_kind_i, flash_status_pkg::OP_PROTECT) ||
                      is_kind(op_kind_i, flash_status_pkg::OP_UNPROTECT) ||
                      is_kind(op_kind_i, flash_status_pkg::OP_LOCKDOWN) ||
                      is_kind(op_kind_i, flash_status_pkg::OP_OTP_PROG) ||
                      is_kind(op_kind_i,
                              flash_status_pkg::OP_HOLD_ABORT)) begin
            state_next.write_latch = 1'b0;
         end
         // any other code is a partial or unknown opcode: no change
      end

      // the reset command clears the latch only; lock and enables stay
      if (soft_reset_i && state_reg.soft_reset_allow) begin
         state_next.write_latch = 1'b0;
      end

      // freeze is permanent until power is removed
      if (state_next.frozen) begin
         state_next.lockdown_allow = 1'b0;
      end

      // ----------------------------------------------------------------
      // visible bytes, built from the next values so reads see no lag
      // ----------------------------------------------------------------
      state_next.byte_one = flash_status_pkg::RST_BYTE;
      state_next.byte_one[flash_status_pkg::B1_LOCK] =
         state_next.protection_lock_bit;
      state_next.byte_one[flash_status_pkg::B1_FAIL] =
         state_next.program_fail_flag;
      state_next.byte_one[flash_status_pkg::B1_PIN] =
         state_next.protect_pin_state;
      state_next.byte_one[flash_status_pkg::B1_SUM_HI:
                          flash_status_pkg::B1_SUM_LO] =
         state_next.soft_protect_summary;
      state_next.byte_one[flash_status_pkg::B1_LATCH] =
         state_next.write_latch;
      state_next.byte_one[flash_status_pkg::B1_BUSY] =
         state_next.ready_busy_flag;

      // upper three bits keep the zero from the base value
      state_next.byte_two = flash_status_pkg::RST_BYTE;
      state_next.byte_two[flash_status_pkg::B2_RST_ALLOW] =
         state_next.soft_reset_allow;
      state_next.byte_two[flash_status_pkg::B2_LD_ALLOW] =
         state_next.lockdown_allow;
      state_next.byte_two[flash_status_pkg::B2_PSUSP] =
         state_next.prog_suspended_flag;
      state_next.byte_two[flash_status_pkg::B2_ESUSP] =
         state_next.erase_suspended_flag;
      state_next.byte_two[flash_status_pkg::B2_BUSY] =
         state_next.ready_busy_flag;

      // ----------------------------------------------------------------
      // permissions; a command must see them before it starts
      // ----------------------------------------------------------------
      state_next.gate_ok = state_next.write_latch;
      state_next.sector_ok = state_next.write_latch &&
         !state_next.protection_lock_bit;
      state_next.ld_ok = state_next.write_latch &&
         state_next.lockdown_allow;
      state_next.rst_ok = state_next.soft_reset_allow;
   end

   // ----------------------------------------------------------------
   // registers; the reset input is the power-up reset
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= '0;
         state_reg.protection_lock_bit <= flash_status_pkg::RST_LOCK;
         state_reg.program_fail_flag <= flash_status_pkg::RST_FAIL;
         state_reg.protect_pin_state <= flash_status_pkg::RST_PIN;
         state_reg.soft_protect_summary <= flash_status_pkg::RST_SUMMARY;
         state_reg.write_latch <= flash_status_pkg::RST_LATCH;
         state_reg.soft_reset_allow <= flash_status_pkg::RST_RST_ALLOW;
         state_reg.lockdown_allow <= flash_status_pkg::RST_LD_ALLOW;
         state_reg.frozen <= flash_status_pkg::RST_FROZEN;
         state_reg.byte_one <= flash_status_pkg::RST_BYTE;
         state_reg.byte_two <= flash_status_pkg::RST_BYTE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign status_byte_one_o = state_reg.byte_one;
   assign status_byte_two_o = state_reg.byte_two;
   assign latch_gate_ok_o = state_reg.gate_ok;
   assign sector_prot_ok_o = state_reg.sector_ok;
   assign lockdown_ok_o = state_reg.ld_ok;
   assign soft_reset_ok_o = state_reg.rst_ok;
   assign global_protect_o = state_reg.glob_prot;
   assign global_unprotect_o = state_reg.glob_unprot;

endmodule // flash_status_regs

`default_nettype wire

// ==== tb/flash_status_regs_monitor.sv ====
/*
 Checker of the flash status register logic, bound to its top module.
 Assumes one clock and the active-low asynchronous power-up reset.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_status_regs_monitor (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // operation reports
   input wire logic op_end_i,
   input wire logic [3:0] op_kind_i,
   input wire logic op_abort_i,
   input wire logic op_fail_i,
   input wire logic [7:0] op_data_i,
   input wire logic soft_reset_i,
   // pins and engine levels
   input wire logic wp_n_i,
   input wire logic busy_i,
   input wire logic prog_susp_i,
   input wire logic erase_susp_i,
   input wire logic none_protected_i,
   input wire logic all_protected_i,
   // block outputs
   input wire logic [7:0] status_byte_one_o,
   input wire logic [7:0] status_byte_two_o,
   input wire logic latch_gate_ok_o,
   input wire logic sector_prot_ok_o,
   input wire logic lockdown_ok_o,
   input wire logic soft_reset_ok_o,
   input wire logic global_protect_o,
   input wire logic global_unprotect_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   wire [7:0] s1 = status_byte_one_o;
   wire [7:0] s2 = status_byte_two_o;
   wire pe = op_kind_i == flash_status_pkg::OP_PROGRAM
      || op_kind_i == flash_status_pkg::OP_ERASE;
   AST_RSVD: assert property (s2[7:5] == 3'h0 && !s1[6])
      else $error("reserved status bit set");
   AST_BUSY: assert property (1'b1 |=> s1[0] == $past(busy_i)
      && s2[0] == $past(busy_i)) else $error("busy bit wrong");
   AST_SUSP_PIN: assert property (1'b1 |=> s1[4] == $past(wp_n_i)
      && s2[2:1] == $past({prog_susp_i, erase_susp_i}))
      else $error("pin or suspend mirror wrong");
   AST_SUMMARY: assert property (none_protected_i != all_protected_i
      |=> s1[3:2] == ($past(all_protected_i) ? 2'h3 : 2'h0))
      else $error("summary code wrong");
   AST_SOME: assert property (!none_protected_i && !all_protected_i
      |=> s1[3:2] == 2'h1) else $error("summary not some");
   AST_LOCK_WP: assert property (!wp_n_i && s1[7] |=> s1[7])
      else $error("lock cleared with pin asserted");
   AST_LOCK_SRC: assert property ($changed(s1[7]) |->
      $past(op_end_i && op_kind_i == flash_status_pkg::OP_WR_STAT1))
      else $error("lock moved without byte one write");
   AST_FAIL_SRC: assert property ($changed(s1[5]) |->
      $past(op_end_i && pe)) else $error("fail flag moved idle");
   AST_FAIL_ABORT: assert property (op_end_i && pe && op_abort_i
      |=> !s1[5]) else $error("fail flag set on abort");
   AST_ALLOW_SRC: assert property ($changed(s2[4:3]) |->
      $past(op_end_i) && ($past(op_kind_i) == flash_status_pkg::OP_WR_STAT2
      || $past(op_kind_i) == flash_status_pkg::OP_FREEZE))
      else $error("enable bits moved without write");
   AST_SOFT_RST: assert property (soft_reset_i && s2[4] |=> !s1[1])
      else $error("latch kept over reset command");
   AST_LATCH_KEEP: assert property (op_end_i && !soft_reset_i
      && op_kind_i inside {4'h0, 4'he, 4'hf} |=> $stable(s1[1]))
      else $error("latch moved on unknown opcode");
   AST_PERMIT: assert property (latch_gate_ok_o == s1[1]
      && sector_prot_ok_o == (s1[1] && !s1[7])
      && lockdown_ok_o == (s1[1] && s2[3]) && soft_reset_ok_o == s2[4])
      else $error("permission levels disagree with bytes");
   AST_GLOBAL: assert property (global_protect_o |-> $past(op_end_i
      && op_kind_i == flash_status_pkg::OP_WR_STAT1 && s1[1] && !s1[7]
      && op_data_i[5:2] == 4'hf) ##1 !global_protect_o)
      else $error("global protect pulse wrong");
   AST_UNPROT: assert property (global_unprotect_o |-> $past(op_end_i
      && op_kind_i == flash_status_pkg::OP_WR_STAT1 && s1[1] && !s1[7]
      && op_data_i[5:2] == 4'h0) ##1 !global_unprotect_o)
      else $error("global unprotect pulse wrong");
   cover property (global_unprotect_o);
   cover property (global_protect_o);
   cover property ($fell(s2[3]));
   cover property (op_end_i && pe && op_fail_i ##1 s1[5]);
endmodule // flash_status_regs_monitor

bind flash_status_regs flash_status_regs_monitor
   u_flash_status_regs_monitor (.core_clk_i, .rst_n_i, .op_end_i,
   .op_kind_i, .op_abort_i, .op_fail_i, .op_data_i, .soft_reset_i,
   .wp_n_i, .busy_i, .prog_susp_i, .erase_susp_i, .none_protected_i,
   .all_protected_i, .status_byte_one_o, .status_byte_two_o,
   .latch_gate_ok_o, .sector_prot_ok_o, .lockdown_ok_o,
   .soft_reset_ok_o, .global_protect_o, .global_unprotect_o);
`default_nettype wire

// ==== tb/op_source.sv ====
/*
 Model of the command front end: reports one finished operation a call.
 Assumes the block takes a report on the edge that sees the pulse high.
*/
`timescale 1ns/1ps
`default_nettype none
module op_source (
   // clock
   input wire logic core_clk_i,
   // operation reports
   output logic op_end_o,
   output logic [3:0] op_kind_o,
   output logic op_abort_o,
   output logic op_fail_o,
   output logic [7:0] op_data_o,
   output logic soft_reset_o
);
   initial begin
      op_end_o = 1'b0;
      op_kind_o = 4'h0;
      op_abort_o = 1'b0;
      op_fail_o = 1'b0;
      op_data_o = 8'h00;
      soft_reset_o = 1'b0;
   end
   // qualifiers flip once the pulse ends, so stale values are never useful
   task automatic report(input logic [3:0] k, input logic [7:0] d = 8'h00,
      input logic ab = 1'b0, input logic fl = 1'b0, input logic sr = 1'b0);
      @(posedge core_clk_i);
      #1;
      op_end_o = 1'b1;
      op_kind_o = k;
      op_data_o = d;
      op_abort_o = ab;
      op_fail_o = fl;
      soft_reset_o = sr;
      @(posedge core_clk_i);
      #1;
      op_end_o = 1'b0;
      soft_reset_o = 1'b0;
      op_kind_o = ~k;
      op_data_o = ~d;
      op_abort_o = ~ab;
      op_fail_o = ~fl;
   endtask
endmodule // op_source
`default_nettype wire

// ==== tb/flash_status_regs_test.sv ====
/*
 Self-checking bench of the flash status register logic.
 Assumes the op_source model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_status_regs_test;
   logic core_clk_i, rst_n_i, wp_n_i, busy_i, prog_susp_i, erase_susp_i;
   logic none_protected_i, all_protected_i;
   logic op_end_i, op_abort_i, op_fail_i, soft_reset_i;
   logic [3:0] op_kind_i;
   logic [7:0] op_data_i, s1, s2;
   logic lgo, spo, ldo, sro, gpo, guo;
   int n_errors = 0;
   int n_checks = 0;
   // disable, config, protect, unprotect, lockdown, otp, hold abort
   logic [3:0] clr [7] = '{4'h2, 4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hd};
   logic [3:0] keep [3] = '{4'h0, 4'he, 4'hf};

   op_source u_op_source (.core_clk_i(core_clk_i), .op_end_o(op_end_i),
      .op_kind_o(op_kind_i), .op_abort_o(op_abort_i),
      .op_fail_o(op_fail_i), .op_data_o(op_data_i),
      .soft_reset_o(soft_reset_i));
   flash_status_regs u_flash_status_regs (.core_clk_i, .rst_n_i, .op_end_i,
      .op_kind_i, .op_abort_i, .op_fail_i, .op_data_i, .soft_reset_i,
      .wp_n_i, .busy_i, .prog_susp_i, .erase_susp_i, .none_protected_i,
      .all_protected_i, .status_byte_one_o(s1), .status_byte_two_o(s2),
      .latch_gate_ok_o(lgo), .sector_prot_ok_o(spo), .lockdown_ok_o(ldo),
      .soft_reset_ok_o(sro), .global_protect_o(gpo),
      .global_unprotect_o(guo));

   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      if (n_errors == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic step;
      @(posedge core_clk_i);
      #1;
   endtask
   task automatic wen;
      u_op_source.report(flash_status_pkg::OP_WR_ENABLE);
   endtask
   task automatic wr(input logic [3:0] k, input logic [7:0] d);
      wen;
      u_op_source.report(k, d);
   endtask

   // ----------------------------------------------------------------
   // scenarios; idle byte one is pin high, summary none
   // ----------------------------------------------------------------
   initial begin
      rst_n_i = 1'b0;
      wp_n_i = 1'b1;
      busy_i = 1'b0;
      prog_susp_i = 1'b0;
      erase_susp_i = 1'b0;
      none_protected_i = 1'b1;
      all_protected_i = 1'b0;
      repeat (20) @(posedge core_clk_i);
      #1;
      rst_n_i = 1'b1;
      step;
      check(s1, 8'h10);
      check(s2, 8'h00);
      for (int i = 5; i >= 0; i--) begin
         busy_i = i[0];
         prog_susp_i = i[1];
         erase_susp_i = i[2];
         wp_n_i = !i[1];
         none_protected_i = i % 3 == 0;
         all_protected_i = i % 3 == 2;
         step;
         check(s1, {3'h0, !i[1], i % 3 == 2, i % 3 != 0, 1'b0, i[0]});
         check(s2, {5'h0, i[1], i[2], i[0]});
      end
      u_op_source.report(flash_status_pkg::OP_WR_STAT2, 8'hff);
      check(s2, 8'h00);
      u_op_source.report(flash_status_pkg::OP_WR_STAT1, 8'hbc);
      check(s1, 8'h10);
      wen;
      check(s1, 8'h12);
      check({4'h0, lgo, spo, ldo, sro}, 8'h0c);
      u_op_source.report(flash_status_pkg::OP_WR_STAT2, 8'hff);
      check(s2, 8'h18);
      check(s1, 8'h10);
      check({4'h0, lgo, spo, ldo, sro}, 8'h01);
      wr(flash_status_pkg::OP_WR_STAT1, 8'hbc);
      check(s1, 8'h90);
      check({6'h0, gpo, guo}, 8'h02);
      step;
      check({6'h0, gpo, guo}, 8'h00);
      wen;
      check({4'h0, lgo, spo, ldo, sro}, 8'h0b);
      u_op_source.report(flash_status_pkg::OP_WR_STAT1, 8'h80);
      check({6'h0, gpo, guo}, 8'h00);
      wp_n_i = 1'b0;
      wr(flash_status_pkg::OP_WR_STAT1, 8'h00);
      check(s1, 8'h80);
      wp_n_i = 1'b1;
      wr(flash_status_pkg::OP_WR_STAT1, 8'h00);
      check(s1, 8'h10);
      wr(flash_status_pkg::OP_WR_STAT1, 8'h00);
      check({6'h0, gpo, guo}, 8'h01);
      wen;
      u_op_source.report(flash_status_pkg::OP_PROGRAM, 8'h00, 1'b0, 1'b1);
      check(s1, 8'h30);
      u_op_source.report(flash_status_pkg::OP_ERASE, 8'h00, 1'b0, 1'b1);
      check(s1, 8'h10);
      wen;
      u_op_source.report(flash_status_pkg::OP_ERASE, 8'h00, 1'b0, 1'b1);
      check(s1, 8'h30);
      wen;
      u_op_source.report(flash_status_pkg::OP_PROGRAM, 8'h00, 1'b1, 1'b1);
      check(s1, 8'h10);
      wen;
      foreach (keep[j]) begin
         u_op_source.report(keep[j]);
         check(s1, 8'h12);
      end
      foreach (clr[j]) begin
         wr(clr[j], 8'h00);
         check(s1, 8'h10);
      end
      wr(flash_status_pkg::OP_WR_STAT1, 8'h80);
      wen;
      u_op_source.report(flash_status_pkg::OP_WR_ENABLE, 8'h00, 1'b0, 1'b0,
         1'b1);
      check(s1, 8'h90);
      check(s2, 8'h18);
      wr(flash_status_pkg::OP_WR_STAT2, 8'h00);
      wen;
      u_op_source.report(flash_status_pkg::OP_NONE, 8'h00, 1'b0, 1'b0, 1'b1);
      check(s1, 8'h92);
      wr(flash_status_pkg::OP_WR_STAT2, 8'h08);
      check(s2, 8'h08);
      wr(flash_status_pkg::OP_FREEZE, 8'h00);
      check(s2, 8'h00);
      wr(flash_status_pkg::OP_WR_STAT2, 8'h18);
      check(s2, 8'h10);
      wen;
      u_op_source.report(flash_status_pkg::OP_WR_STAT2, 8'h00, 1'b1);
      check(s2, 8'h10);
      check(s1, 8'h90);
      rst_n_i = 1'b0;
      step;
      rst_n_i = 1'b1;
      step;
      check(s1, 8'h10);
      check(s2, 8'h00);
      complete_run;
   end

   // a hung handshake ends the run as a failure
   initial begin
      repeat (5000) @(posedge core_clk_i);
      n_errors++;
      complete_run;
   end
endmodule // flash_status_regs_test
`default_nettype wire
